// ==== verilog/main_clock_pll_control.sv ====
/*
 Main clock, PLL and slow clock source control with an AHB-Lite register slave.
 Assumes slow_clock, main_clock and fast_rc_ready arrive from analogue macros
 asynchronous to hclk, and main_clock is well below half the hclk rate.
*/
// How it works
// - Slow bypass bit set routes an external slow clock from the slow input pin.
// - Slow source select picks the 32 kHz RC at 0, 32768 Hz oscillator at 1.
// - Reset leaves fast RC enabled, crystal off and RC selected as main source.
// - Main bypass bit set accepts an external clock on the main input pin.
// - Selecting the crystal before it is ready forces the select back to RC.
// - Clearing the fast RC enable clears the fast RC stable flag.
// - Fast RC stable flag can raise the interrupt when unmasked.
// - Clearing the crystal enable clears the crystal stable flag.
// - Enabling crystal with a count clears stable and counts down on slow/8.
// - Crystal counter reaching zero sets the stable flag, interrupt capable.
// - Main source switches glitch-free; a done flag reports it, interrupt capable.
// - Frequency counter restarts at next slow rise on stable or selection change.
// - At the 16th slow fall the counter stops and its ready flag sets.
// - Input divider 1 to 255; zero holds divider and PLL output at zero.
// - PLL factor is multiplier plus one over divider; multiplier zero disables.
// - PLL enable or change clears lock, loads count, counts slow clocks to lock.
// - Half-divide bit halves the system PLL output clock.
// - USB PLL enable clears lock, loads count, counts slow/8 to lock.
`timescale 1ns/10ps
module main_clock_pll_control (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analogue status inputs
	input wire logic slow_clock,
	input wire logic main_clock,
	input wire logic fast_rc_ready,
	// Slow clock controls
	output logic slow_rc_enable,
	output logic slow_osc_enable,
	output logic slow_crystal_bypass,
	output logic slow_source_select,
	// Main clock controls
	output logic fast_rc_enable,
	output logic main_crystal_enable,
	output logic main_crystal_bypass,
	output logic main_source_select,
	// PLL controls
	output logic [7:0] pll_input_prescale,
	output logic [7:0] pll_multiplier_field,
	output logic system_pll_enable,
	output logic pll_half_divide,
	output logic usb_pll_enable,
	// Interrupt
	output logic irq
);

	logic slow_rise;
	logic slow_fall;
	logic main_rise;
	logic rc_ready_lvl;
	logic wr_pend_ff;
	logic [7:0] addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_word;
	logic [31:0] status;
	logic take;
	logic mor_wr;
	logic pll_wr;
	logic uck_wr;
	logic fast_rc_enable_ff;
	logic main_crystal_enable_ff;
	logic main_crystal_bypass_ff;
	logic [7:0] crystal_startup_count_ff;
	logic sel_req_ff;
	logic main_source_select_ff;
	logic source_switch_done_flag_ff;
	logic [1:0] sw_cnt_ff;
	logic [2:0] div8_ff;
	logic div8_tick;
	logic [7:0] xtal_cnt_ff;
	logic xtal_run_ff;
	logic crystal_stable_flag_ff;
	logic crystal_ready_status;
	logic fast_rc_stable_flag_ff;
	logic rc_stable_d_ff;
	logic xtal_stable_d_ff;
	logic sel_d_ff;
	logic fm_trigger;
	clk_ctrl_pkg::freq_state_e fm_ff;
	logic [3:0] periods_ff;
	logic [15:0] main_freq_value_ff;
	logic freq_count_ready_ff;
	logic [7:0] pll_input_prescale_ff;
	logic [7:0] pll_multiplier_field_ff;
	logic [5:0] system_pll_lock_count_ff;
	logic [5:0] pll_cnt_ff;
	logic pll_run_ff;
	logic system_pll_lock_flag_ff;
	logic system_pll_enable_ff;
	logic pll_half_divide_ff;
	logic usb_pll_enable_ff;
	logic [3:0] usb_pll_lock_count_ff;
	logic [3:0] usb_cnt_ff;
	logic usb_run_ff;
	logic usb_pll_lock_flag_ff;
	logic [3:0] sckcr_ff;
	logic [31:0] power_interrupt_mask_ff;
	logic irq_ff;

	// Pin synchronisers for slow clock, main clock and RC ready
	pin_sync3 u_slow (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(slow_clock),
		.level(),
		.rise(slow_rise),
		.fall(slow_fall)
	);

	pin_sync3 u_main (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(main_clock),
		.level(),
		.rise(main_rise),
		.fall()
	);

	pin_sync3 u_rcrdy (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(fast_rc_ready),
		.level(rc_ready_lvl),
		.rise(),
		.fall()
	);

	// Bus address phase: zero wait states, always OKAY
	assign take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= take & hwrite;
			if (take) begin
				addr_ff <= haddr[7:0];
			end
		end
	end

	// Write strobes in the data phase
	assign mor_wr = wr_pend_ff & (addr_ff == clk_ctrl_pkg::MOR_OFS);
	assign pll_wr = wr_pend_ff & (addr_ff == clk_ctrl_pkg::PLLAR_OFS);
	assign uck_wr = wr_pend_ff & (addr_ff == clk_ctrl_pkg::UCKR_OFS);

	// Slow clock divided by 8
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div8_ff <= 3'h0;
		end else if (slow_rise) begin
			div8_ff <= div8_ff + 3'h1;
		end
	end

	assign div8_tick = slow_rise & (div8_ff == clk_ctrl_pkg::SLOW_DIV8_LAST);

	// Main oscillator register
	assign crystal_ready_status = crystal_stable_flag_ff | main_crystal_bypass_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_rc_enable_ff <= clk_ctrl_pkg::MOR_RST[clk_ctrl_pkg::MOR_RCEN];
			main_crystal_enable_ff <= clk_ctrl_pkg::MOR_RST[clk_ctrl_pkg::MOR_XTEN];
			main_crystal_bypass_ff <= clk_ctrl_pkg::MOR_RST[clk_ctrl_pkg::MOR_XTBY];
			crystal_startup_count_ff <= 8'h00;
			sel_req_ff <= clk_ctrl_pkg::MOR_RST[clk_ctrl_pkg::MOR_SEL];
		end else if (mor_wr) begin
			fast_rc_enable_ff <= hwdata[clk_ctrl_pkg::MOR_RCEN];
			main_crystal_enable_ff <= hwdata[clk_ctrl_pkg::MOR_XTEN];
			main_crystal_bypass_ff <= hwdata[clk_ctrl_pkg::MOR_XTBY];
			crystal_startup_count_ff <= hwdata[clk_ctrl_pkg::MOR_CNT_LSB +: 8];
			sel_req_ff <= hwdata[clk_ctrl_pkg::MOR_SEL] & crystal_ready_status;
		end
	end

	// Crystal startup countdown
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xtal_cnt_ff <= 8'h00;
			xtal_run_ff <= 1'b0;
			crystal_stable_flag_ff <= 1'b0;
		end else if (mor_wr && !hwdata[clk_ctrl_pkg::MOR_XTEN]) begin
			xtal_run_ff <= 1'b0;
			crystal_stable_flag_ff <= 1'b0;
		end else if (mor_wr && (!main_crystal_enable_ff ||
				hwdata[clk_ctrl_pkg::MOR_CNT_LSB +: 8] != crystal_startup_count_ff)) begin
			xtal_cnt_ff <= hwdata[clk_ctrl_pkg::MOR_CNT_LSB +: 8];
			xtal_run_ff <= 1'b1;
			crystal_stable_flag_ff <= 1'b0;
		end else if (xtal_run_ff && div8_tick) begin
			if (xtal_cnt_ff == 8'h00) begin
				xtal_run_ff <= 1'b0;
				crystal_stable_flag_ff <= 1'b1;
			end else begin
				xtal_cnt_ff <= xtal_cnt_ff - 8'h01;
			end
		end
	end

	// Fast RC stable follows its enable and the synchronised ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_rc_stable_flag_ff <= 1'b0;
		end else begin
			fast_rc_stable_flag_ff <= fast_rc_enable_ff & rc_ready_lvl;
		end
	end

	// Glitch-free source switch, applied after two slow edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_source_select_ff <= 1'b0;
			source_switch_done_flag_ff <= 1'b1;
			sw_cnt_ff <= 2'h0;
		end else if (sel_req_ff != main_source_select_ff) begin
			source_switch_done_flag_ff <= 1'b0;
			if (slow_rise) begin
				if (sw_cnt_ff == clk_ctrl_pkg::SWITCH_LAST_EDGE) begin
					main_source_select_ff <= sel_req_ff;
					source_switch_done_flag_ff <= 1'b1;
					sw_cnt_ff <= 2'h0;
				end else begin
					sw_cnt_ff <= sw_cnt_ff + 2'h1;
				end
			end
		end else begin
			sw_cnt_ff <= 2'h0;
		end
	end

	// Delayed copies for frequency meter triggers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_stable_d_ff <= 1'b0;
			xtal_stable_d_ff <= 1'b0;
			sel_d_ff <= 1'b0;
		end else begin
			rc_stable_d_ff <= fast_rc_stable_flag_ff;
			xtal_stable_d_ff <= crystal_stable_flag_ff;
			sel_d_ff <= main_source_select_ff;
		end
	end

	assign fm_trigger = (fast_rc_stable_flag_ff & ~rc_stable_d_ff & ~main_source_select_ff) |
		(crystal_stable_flag_ff & ~xtal_stable_d_ff & main_source_select_ff) |
		(main_source_select_ff ^ sel_d_ff);

	// Main clock frequency meter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fm_ff <= clk_ctrl_pkg::FM_IDLE;
			periods_ff <= 4'h0;
			main_freq_value_ff <= 16'h0000;
			freq_count_ready_ff <= 1'b0;
		end else if (fm_trigger) begin
			fm_ff <= clk_ctrl_pkg::FM_ARMED;
			freq_count_ready_ff <= 1'b0;
		end else begin
			case (fm_ff)
				clk_ctrl_pkg::FM_ARMED: begin
					if (slow_rise) begin
						main_freq_value_ff <= 16'h0000;
						periods_ff <= 4'h0;
						fm_ff <= clk_ctrl_pkg::FM_COUNT;
					end
				end
				clk_ctrl_pkg::FM_COUNT: begin
					if (main_rise) begin
						main_freq_value_ff <= main_freq_value_ff + 16'h0001;
					end
					if (slow_fall) begin
						periods_ff <= periods_ff + 4'h1;
						if (periods_ff == clk_ctrl_pkg::FREQ_LAST_PERIOD) begin
							fm_ff <= clk_ctrl_pkg::FM_DONE;
							freq_count_ready_ff <= 1'b1;
						end
					end
				end
				clk_ctrl_pkg::FM_IDLE, clk_ctrl_pkg::FM_DONE: begin
					fm_ff <= fm_ff;
				end
				default: begin
					fm_ff <= clk_ctrl_pkg::FM_IDLE;
				end
			endcase
		end
	end

	// System PLL register and lock counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_input_prescale_ff <= 8'h00;
			pll_multiplier_field_ff <= 8'h00;
			system_pll_lock_count_ff <= 6'h00;
			system_pll_enable_ff <= 1'b0;
		end else if (pll_wr) begin
			pll_input_prescale_ff <= hwdata[clk_ctrl_pkg::PLL_DIV_LSB +: 8];
			pll_multiplier_field_ff <= hwdata[clk_ctrl_pkg::PLL_MUL_LSB +: 8];
			system_pll_lock_count_ff <= hwdata[clk_ctrl_pkg::PLL_CNT_LSB +: 6];
			system_pll_enable_ff <= (hwdata[clk_ctrl_pkg::PLL_MUL_LSB +: 8] != 8'h00) &&
				(hwdata[clk_ctrl_pkg::PLL_DIV_LSB +: 8] != 8'h00);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_cnt_ff <= 6'h00;
			pll_run_ff <= 1'b0;
			system_pll_lock_flag_ff <= 1'b0;
		end else if (pll_wr) begin
			system_pll_lock_flag_ff <= 1'b0;
			pll_cnt_ff <= hwdata[clk_ctrl_pkg::PLL_CNT_LSB +: 6];
			pll_run_ff <= (hwdata[clk_ctrl_pkg::PLL_MUL_LSB +: 8] != 8'h00) &&
				(hwdata[clk_ctrl_pkg::PLL_DIV_LSB +: 8] != 8'h00);
		end else if (pll_run_ff && slow_rise) begin
			if (pll_cnt_ff == 6'h00) begin
				pll_run_ff <= 1'b0;
				system_pll_lock_flag_ff <= 1'b1;
			end else begin
				pll_cnt_ff <= pll_cnt_ff - 6'h01;
			end
		end
	end

	// Master clock half-divide bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_half_divide_ff <= 1'b0;
		end else if (wr_pend_ff && addr_ff == clk_ctrl_pkg::MCKR_OFS) begin
			pll_half_divide_ff <= hwdata[clk_ctrl_pkg::MCK_HALF];
		end
	end

	// USB PLL register and lock counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb_pll_enable_ff <= 1'b0;
			usb_pll_lock_count_ff <= 4'h0;
			usb_cnt_ff <= 4'h0;
			usb_run_ff <= 1'b0;
			usb_pll_lock_flag_ff <= 1'b0;
		end else if (uck_wr) begin
			usb_pll_enable_ff <= hwdata[clk_ctrl_pkg::UCK_EN];
			usb_pll_lock_count_ff <= hwdata[clk_ctrl_pkg::UCK_CNT_LSB +: 4];
			usb_cnt_ff <= hwdata[clk_ctrl_pkg::UCK_CNT_LSB +: 4];
			usb_run_ff <= hwdata[clk_ctrl_pkg::UCK_EN];
			usb_pll_lock_flag_ff <= 1'b0;
		end else if (usb_run_ff && div8_tick) begin
			if (usb_cnt_ff == 4'h0) begin
				usb_run_ff <= 1'b0;
				usb_pll_lock_flag_ff <= 1'b1;
			end else begin
				usb_cnt_ff <= usb_cnt_ff - 4'h1;
			end
		end
	end

	// Slow clock control and interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sckcr_ff <= clk_ctrl_pkg::SCKCR_RST;
			power_interrupt_mask_ff <= 32'h0000_0000;
		end else if (wr_pend_ff) begin
			if (addr_ff == clk_ctrl_pkg::SCKCR_OFS) begin
				sckcr_ff <= hwdata[3:0];
			end
			if (addr_ff == clk_ctrl_pkg::IMR_OFS) begin
				power_interrupt_mask_ff <= hwdata;
			end
		end
	end

	// Status word
	always_comb begin
		status = 32'h0000_0000;
		status[clk_ctrl_pkg::ST_XTAL] = crystal_stable_flag_ff;
		status[clk_ctrl_pkg::ST_LOCK_SYS] = system_pll_lock_flag_ff;
		status[clk_ctrl_pkg::ST_LOCK_USB] = usb_pll_lock_flag_ff;
		status[clk_ctrl_pkg::ST_SEL_DONE] = source_switch_done_flag_ff;
		status[clk_ctrl_pkg::ST_RC] = fast_rc_stable_flag_ff;
	end

	// Interrupt from masked status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status & power_interrupt_mask_ff);
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[7:0])
			clk_ctrl_pkg::MOR_OFS: begin
				rd_word[clk_ctrl_pkg::MOR_RCEN] = fast_rc_enable_ff;
				rd_word[clk_ctrl_pkg::MOR_XTEN] = main_crystal_enable_ff;
				rd_word[clk_ctrl_pkg::MOR_XTBY] = main_crystal_bypass_ff;
				rd_word[clk_ctrl_pkg::MOR_CNT_LSB +: 8] = crystal_startup_count_ff;
				rd_word[clk_ctrl_pkg::MOR_SEL] = sel_req_ff;
			end
			clk_ctrl_pkg::MCFR_OFS: begin
				rd_word[15:0] = main_freq_value_ff;
				rd_word[clk_ctrl_pkg::MCFR_RDY] = freq_count_ready_ff;
			end
			clk_ctrl_pkg::PLLAR_OFS: begin
				rd_word[clk_ctrl_pkg::PLL_DIV_LSB +: 8] = pll_input_prescale_ff;
				rd_word[clk_ctrl_pkg::PLL_CNT_LSB +: 6] = system_pll_lock_count_ff;
				rd_word[clk_ctrl_pkg::PLL_MUL_LSB +: 8] = pll_multiplier_field_ff;
			end
			clk_ctrl_pkg::UCKR_OFS: begin
				rd_word[clk_ctrl_pkg::UCK_EN] = usb_pll_enable_ff;
				rd_word[clk_ctrl_pkg::UCK_CNT_LSB +: 4] = usb_pll_lock_count_ff;
			end
			clk_ctrl_pkg::MCKR_OFS: begin
				rd_word[clk_ctrl_pkg::MCK_HALF] = pll_half_divide_ff;
			end
			clk_ctrl_pkg::SR_OFS: begin
				rd_word = status;
			end
			clk_ctrl_pkg::IMR_OFS: begin
				rd_word = power_interrupt_mask_ff;
			end
			clk_ctrl_pkg::SCKCR_OFS: begin
				rd_word[3:0] = sckcr_ff;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Read data captured at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata_ff <= rd_word;
		end
	end

	// Outputs
	assign hrdata = hrdata_ff;
	assign slow_rc_enable = sckcr_ff[clk_ctrl_pkg::SCK_RCEN];
	assign slow_osc_enable = sckcr_ff[clk_ctrl_pkg::SCK_OSCEN];
	assign slow_crystal_bypass = sckcr_ff[clk_ctrl_pkg::SCK_BYP];
	assign slow_source_select = sckcr_ff[clk_ctrl_pkg::SCK_SEL];
	assign fast_rc_enable = fast_rc_enable_ff;
	assign main_crystal_enable = main_crystal_enable_ff;
	assign main_crystal_bypass = main_crystal_bypass_ff;
	assign main_source_select = main_source_select_ff;
	assign pll_input_prescale = pll_input_prescale_ff;
	assign pll_multiplier_field = pll_multiplier_field_ff;
	assign system_pll_enable = system_pll_enable_ff;
	assign pll_half_divide = pll_half_divide_ff;
	assign usb_pll_enable = usb_pll_enable_ff;
	assign irq = irq_ff;

endmodule // main_clock_pll_control

// ==== include/clk_ctrl_pkg.sv ====
/*
 Constants shared by the main clock and PLL control block: register offsets,
 field positions, reset values, cycle counts and the frequency meter states.
 Assumes a 32-bit AHB-Lite register bus decoding the low eight address bits.
*/
package clk_ctrl_pkg;

	// Register byte offsets
	localparam logic [7:0] MOR_OFS = 8'h00;
	localparam logic [7:0] MCFR_OFS = 8'h04;
	localparam logic [7:0] PLLAR_OFS = 8'h08;
	localparam logic [7:0] UCKR_OFS = 8'h0C;
	localparam logic [7:0] MCKR_OFS = 8'h10;
	localparam logic [7:0] SR_OFS = 8'h14;
	localparam logic [7:0] IMR_OFS = 8'h18;
	localparam logic [7:0] SCKCR_OFS = 8'h1C;

	// Main oscillator register fields
	localparam int MOR_RCEN = 0;
	localparam int MOR_XTEN = 1;
	localparam int MOR_XTBY = 2;
	localparam int MOR_CNT_LSB = 8;
	localparam int MOR_SEL = 24;
	localparam logic [31:0] MOR_RST = 32'h0000_0001;

	// Frequency register fields
	localparam int MCFR_RDY = 16;

	// System PLL register fields
	localparam int PLL_DIV_LSB = 0;
	localparam int PLL_CNT_LSB = 8;
	localparam int PLL_MUL_LSB = 16;

	// USB PLL register fields
	localparam int UCK_EN = 16;
	localparam int UCK_CNT_LSB = 20;

	// Master clock register field
	localparam int MCK_HALF = 12;

	// Status and mask bit positions
	localparam int ST_XTAL = 0;
	localparam int ST_LOCK_SYS = 1;
	localparam int ST_LOCK_USB = 6;
	localparam int ST_SEL_DONE = 16;
	localparam int ST_RC = 17;

	// Slow clock control fields and reset value
	localparam int SCK_RCEN = 0;
	localparam int SCK_OSCEN = 1;
	localparam int SCK_BYP = 2;
	localparam int SCK_SEL = 3;
	localparam logic [3:0] SCKCR_RST = 4'h1;

	// Cycle counts
	localparam logic [2:0] SLOW_DIV8_LAST = 3'h7;
	localparam logic [3:0] FREQ_LAST_PERIOD = 4'hF;
	localparam logic [1:0] SWITCH_LAST_EDGE = 2'h1;

	// Frequency meter states
	typedef enum logic [1:0] {
		FM_IDLE,
		FM_ARMED,
		FM_COUNT,
		FM_DONE
	} freq_state_e;

endpackage

// ==== verilog/pin_sync3.sv ====
/*
 Three-flop synchroniser with agreement filter for a pin or foreign clock.
 Assumes the input is asynchronous to clk; outputs are one-cycle edge pulses
 and a filtered level, all on clk.
*/
`timescale 1ns/10ps
module pin_sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin side
	input wire logic async_in,
	// Synchronised side
	output logic level,
	output logic rise,
	output logic fall
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	logic agree;

	// Shift chain; first stage only feeds the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign agree = (s2_ff == s3_ff);

	// Filtered level moves only when stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_ff <= 1'b0;
		end else if (agree) begin
			lvl_ff <= s3_ff;
		end
	end

	assign level = lvl_ff;
	assign rise = agree & s3_ff & ~lvl_ff;
	assign fall = agree & ~s3_ff & lvl_ff;

endmodule // pin_sync3

// ==== verification/clk_ctrl_checker_assertions.sv ====
/*
 Port checker for the clock control block.
 Assumes one hclk domain and hready tied to hreadyout.
*/
`timescale 1ns/10ps
module clk_ctrl_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Controls
	input wire logic fast_rc_enable,
	input wire logic main_crystal_bypass,
	input wire logic main_source_select,
	input wire logic slow_crystal_bypass,
	input wire logic slow_source_select,
	input wire logic [7:0] pll_input_prescale,
	input wire logic [7:0] pll_multiplier_field,
	input wire logic system_pll_enable,
	input wire logic pll_half_divide,
	input wire logic usb_pll_enable,
	input wire logic irq
);
	logic wr_ff;
	logic [7:0] ofs_ff;
	logic [31:0] wd_ff;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Write address phase and its data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			ofs_ff <= 8'h00;
			wd_ff <= 32'h0000_0000;
		end else begin
			wr_ff <= hsel & hready & htrans[1] & hwrite;
			ofs_ff <= haddr[7:0];
			wd_ff <= hwdata;
		end
	end
	chk_bus_okay:
		assert property (hreadyout && !hresp) else $error("bus wait or error");
	chk_reset_state:
		assert property ($rose(hresetn) |-> fast_rc_enable && !main_source_select) else $error("bad reset state");
	chk_div_zero:
		assert property (pll_input_prescale == 8'h00 |-> !system_pll_enable) else $error("pll on, divider 0");
	chk_mul_zero:
		assert property (pll_multiplier_field == 8'h00 |-> !system_pll_enable) else $error("pll on, mul 0");
	chk_pll_write:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::PLLAR_OFS |=>
			system_pll_enable == (wd_ff[7:0] != 8'h00 && wd_ff[23:16] != 8'h00)) else $error("pll enable");
	chk_half_div:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::MCKR_OFS |=> pll_half_divide == wd_ff[12])
			else $error("half divide");
	chk_usb_enable:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::UCKR_OFS |=> usb_pll_enable == wd_ff[16])
			else $error("usb enable");
	chk_slow_bypass:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::SCKCR_OFS |=> slow_crystal_bypass == wd_ff[2])
			else $error("slow bypass");
	chk_slow_select:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::SCKCR_OFS |=> slow_source_select == wd_ff[3])
			else $error("slow select");
	chk_main_bypass:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::MOR_OFS |=> main_crystal_bypass == wd_ff[2])
			else $error("main bypass");
	chk_rc_enable:
		assert property (wr_ff && ofs_ff == clk_ctrl_pkg::MOR_OFS |=> fast_rc_enable == wd_ff[0])
			else $error("rc enable");
	cover property (irq);
	cover property ($rose(system_pll_enable));
	cover property ($rose(main_source_select));
endmodule // clk_ctrl_checker

bind main_clock_pll_control clk_ctrl_checker i_clk_ctrl_checker (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .fast_rc_enable(fast_rc_enable),
	.main_crystal_bypass(main_crystal_bypass), .main_source_select(main_source_select),
	.slow_crystal_bypass(slow_crystal_bypass), .slow_source_select(slow_source_select),
	.pll_input_prescale(pll_input_prescale), .pll_multiplier_field(pll_multiplier_field),
	.system_pll_enable(system_pll_enable), .pll_half_divide(pll_half_divide),
	.usb_pll_enable(usb_pll_enable), .irq(irq));

// ==== verification/analog_model.sv ====
/*
 Behavioural oscillators: free slow clock, main clock and fast RC ready.
 Assumes the block's enable and select outputs drive it.
*/
`timescale 1ns/10ps
module analog_model (
	// Controls
	input wire logic fast_rc_enable,
	input wire logic main_source_select,
	// Oscillator outputs
	output logic slow_clock,
	output logic main_clock,
	output logic fast_rc_ready
);
	initial slow_clock = 1'b0;
	initial main_clock = 1'b0;
	initial fast_rc_ready = 1'b0;
	// Permanent slow clock, shortened period
	always #100 slow_clock = ~slow_clock;
	// RC near 12 MHz, crystal 10 MHz; stops when RC source is off
	always begin
		#(main_source_select === 1'b1 ? 50 : 40);
		if (fast_rc_enable || main_source_select) main_clock = ~main_clock;
	end
	// RC startup delay
	always @(fast_rc_enable) fast_rc_ready <= #300 fast_rc_enable;
endmodule // analog_model

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for the clock control block.
 Assumes one bus slave, so hready follows hreadyout.
*/
`timescale 1ns/10ps
module tb_top;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic hready;
	logic hreadyout;
	logic slow_clock;
	logic main_clock;
	logic fast_rc_ready;
	logic fast_rc_enable;
	logic main_source_select;
	logic system_pll_enable;
	logic irq;
	int err_total = 0;
	int samples_checked = 0;
	row_s rows [6] = '{
		'{clk_ctrl_pkg::SCKCR_OFS, 32'h0000_000E, 32'h0000_000E},
		'{clk_ctrl_pkg::MCKR_OFS, 32'h0000_1000, 32'h0000_1000},
		'{clk_ctrl_pkg::PLLAR_OFS, 32'h0005_0000, 32'h0005_0000},
		'{clk_ctrl_pkg::MOR_OFS, 32'h0100_0001, 32'h0000_0001},
		'{8'h20, 32'hFFFF_FFFF, 32'h0000_0000},
		'{clk_ctrl_pkg::IMR_OFS, 32'h0000_0001, 32'h0000_0001}
	};
	assign hready = hreadyout;
	// Bus clock
	always #5 hclk = ~hclk;
	main_clock_pll_control i_main_clock_pll_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .slow_clock(slow_clock), .main_clock(main_clock),
		.fast_rc_ready(fast_rc_ready), .slow_rc_enable(), .slow_osc_enable(), .slow_crystal_bypass(),
		.slow_source_select(), .fast_rc_enable(fast_rc_enable), .main_crystal_enable(),
		.main_crystal_bypass(), .main_source_select(main_source_select), .pll_input_prescale(),
		.pll_multiplier_field(), .system_pll_enable(system_pll_enable), .pll_half_divide(),
		.usb_pll_enable(), .irq(irq));
	analog_model i_analog_model (.fast_rc_enable(fast_rc_enable), .main_source_select(main_source_select),
		.slow_clock(slow_clock), .main_clock(main_clock), .fast_rc_ready(fast_rc_ready));
	// One single transfer; read data lands in q
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Read until a bit is set, bounded
	task automatic poll(input logic [7:0] a, input int b);
		int i = 0;
		do begin
			xfer(a, 1'b0, 32'h0);
			i++;
		end while (q[b] !== 1'b1 && i < 3000);
	endtask
	task automatic wait_sel(input logic v);
		int i = 0;
		while (main_source_select !== v && i < 2000) begin
			@(posedge hclk);
			i++;
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#300000;
		err_total++;
		give_verdict();
	end
	// Main sequence
	initial begin
		time t0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b0, 32'h0);
		cmp("mor_reset", 32'h0000_0001, q);
		foreach (rows[k]) begin
			xfer(rows[k].a, 1'b1, rows[k].d);
			xfer(rows[k].a, 1'b0, 32'h0);
			cmp("row_read", rows[k].e, q);
		end
		cmp("irq_idle", 32'h0, irq);
		t0 = $time;
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0000_0303);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("xtal_cleared", 32'h0, q[0]);
		poll(clk_ctrl_pkg::SR_OFS, clk_ctrl_pkg::ST_XTAL);
		cmp("xtal_stable", 32'h1, q[0]);
		cmp("xtal_time", 32'h1, ($time - t0 >= 4800) && ($time - t0 <= 7400));
		repeat (3) @(posedge hclk);
		cmp("irq_xtal", 32'h1, irq);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0100_0303);
		wait_sel(1'b1);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("switch_done", 32'h1, q[16]);
		poll(clk_ctrl_pkg::MCFR_OFS, clk_ctrl_pkg::MCFR_RDY);
		cmp("freq_ready", 32'h1, q[16]);
		cmp("freq_value", 32'h1, q[15:0] >= 30 && q[15:0] <= 34);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0000_0303);
		wait_sel(1'b0);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0000_0001);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("xtal_off", 32'h0, q[0]);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0);
		@(posedge hclk);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("rc_off", 32'h0, q[17]);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b1, 32'h0000_0005);
		xfer(clk_ctrl_pkg::PLLAR_OFS, 1'b1, 32'h0004_0501);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("pll_unlocked", 32'h0, q[1]);
		poll(clk_ctrl_pkg::SR_OFS, clk_ctrl_pkg::ST_LOCK_SYS);
		cmp("pll_locked", 32'h1, q[1]);
		cmp("pll_enable", 32'h1, system_pll_enable);
		xfer(clk_ctrl_pkg::UCKR_OFS, 1'b1, 32'h0021_0000);
		xfer(clk_ctrl_pkg::SR_OFS, 1'b0, 32'h0);
		cmp("usb_unlocked", 32'h0, q[6]);
		poll(clk_ctrl_pkg::SR_OFS, clk_ctrl_pkg::ST_LOCK_USB);
		cmp("usb_locked", 32'h1, q[6]);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(clk_ctrl_pkg::MOR_OFS, 1'b0, 32'h0);
		cmp("mor_rereset", 32'h0000_0001, q);
		cmp("pll_rereset", 32'h0, system_pll_enable);
		give_verdict();
	end
endmodule // tb_top
